// ---- src/fpwm_pkg.sv ----
package fpwm_pkg;
  localparam int          CLK_HZ          = 10_000_000;
  localparam int          FAN_OUTS        = 3;
  localparam int          FAILSAFE_MS     = 4600;
  localparam int          FAILSAFE_CYCLES = FAILSAFE_MS * (CLK_HZ / 1000);
  localparam int          DETECT_US       = 5000;
  localparam int          DETECT_CYCLES   = DETECT_US * (CLK_HZ / 1_000_000);
  localparam int          PWM_DIV_DEFAULT = 4;
  localparam int          THERMAL_LIMIT_PIN_TIMER_W   = 16;
  localparam logic [7:0]  OFS_DUTY_1      = 8'h30;
  localparam logic [7:0]  OFS_DUTY_2      = 8'h31;
  localparam logic [7:0]  OFS_DUTY_3      = 8'h32;
  localparam logic [7:0]  OFS_TUNE_CTRL   = 8'h36;
  localparam logic [7:0]  OFS_BOARD_TEST  = 8'h6f;
  localparam logic [7:0]  OFS_DETECT_CFG  = 8'h73;
  localparam logic [7:0]  DUTY_RST        = 8'hff;
  localparam logic [7:0]  DUTY_FULL       = 8'hff;
  localparam logic [7:0]  TUNE_RST        = 8'h00;
  localparam logic [7:0]  BOARD_TEST_RST  = 8'h00;
  localparam logic [7:0]  DETECT_CFG_RST  = 8'h00;
  localparam logic [7:0]  START_TEMP_RST  = 8'h9a;
  localparam int          HOLD_EN_BIT     = 1;
  localparam int          DET_START_BIT   = 0;
  localparam int          DET_PRES_LSB    = 1;
  localparam int          XEN_BIT         = 0;
  localparam logic [2:0]  DRIVE_BEHAVIOUR_SELECT_MANUAL     = 3'h7;
endpackage

// ---- src/fpwm_ctl_if.sv ----
interface fpwm_ctl_if #(parameter int N = 3);
  logic                tick;
  logic [N-1:0][7:0]   duty;
  logic [N-1:0]        drv;
  logic                rail_up;
  logic                access;
  logic                force_full;
  logic                load_defaults;
  modport pwm (input tick, input duty, output drv);
  modport fs  (input rail_up, input access, output force_full, output load_defaults);
  modport top (output tick, output duty, output rail_up, output access,
               input drv, input force_full, input load_defaults);
endinterface

// ---- src/fpwm_gen.sv ----
module fpwm_gen import fpwm_pkg::*; #(
  parameter int N = FAN_OUTS
) (
  // Clock and reset
  input  wire logic    clk,
  input  wire logic    rst,
  // Duty in, drive out
  fpwm_ctl_if.pwm      ctl
);
  logic [7:0]   cnt_q;
  logic [N-1:0] drv_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 8'h00;
    end else if (ctl.tick) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // Code 0xff is held high for the whole period so full duty is truly 100%.
  always_ff @(posedge clk) begin
    if (rst) begin
      drv_q <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        drv_q[i] <= (ctl.duty[i] == DUTY_FULL) || (cnt_q < ctl.duty[i]);
      end
    end
  end

  assign ctl.drv = drv_q;

  full_duty_a: assert property (@(posedge clk) disable iff (rst)
    (ctl.duty[0] == DUTY_FULL) |=> ctl.drv[0])
    else $error("full duty code did not hold the drive high");
  zero_duty_a: assert property (@(posedge clk) disable iff (rst)
    (ctl.duty[1] == 8'h00) |=> !ctl.drv[1])
    else $error("zero duty code drove the output high");
endmodule

// ---- src/fpwm_failsafe.sv ----
module fpwm_failsafe import fpwm_pkg::*; #(
  parameter int FS_CYCLES = FAILSAFE_CYCLES,
  parameter bit POLL_RAIL = 1'b1
) (
  // Clock and reset
  input  wire logic    clk,
  input  wire logic    rst,
  // Power-up supervision
  fpwm_ctl_if.fs       ctl
);
  typedef enum logic [1:0] {FS_WAIT, FS_COUNT, FS_FULL, FS_NORMAL} fpwm_fs_state_t;

  localparam int CW = $clog2(FS_CYCLES + 1);

  fpwm_fs_state_t st_q;
  logic [CW-1:0]  cnt_q;
  logic           load_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q   <= POLL_RAIL ? FS_WAIT : FS_FULL;
      cnt_q  <= '0;
      load_q <= 1'b0;
    end else begin
      load_q <= 1'b0;
      case (st_q)
        FS_WAIT: begin
          if (ctl.access) begin
            st_q <= FS_NORMAL;
          end else if (ctl.rail_up) begin
            st_q  <= FS_COUNT;
            cnt_q <= '0;
          end
        end
        FS_COUNT: begin
          if (ctl.access) begin
            st_q <= FS_NORMAL;
          end else if (cnt_q == CW'(FS_CYCLES - 1)) begin
            st_q <= FS_FULL;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        FS_FULL: begin
          if (ctl.access) begin
            st_q   <= FS_NORMAL;
            load_q <= 1'b1;
          end
        end
        FS_NORMAL: begin
          st_q <= FS_NORMAL;
        end
        default: begin
          st_q <= FS_FULL;
        end
      endcase
    end
  end

  assign ctl.force_full    = (st_q == FS_FULL);
  assign ctl.load_defaults = load_q;

  sequence last_count_s;
    (st_q == FS_COUNT) && (cnt_q == CW'(FS_CYCLES - 1)) && !ctl.access;
  endsequence
  sequence release_s;
    ctl.load_defaults && !ctl.force_full;
  endsequence

  timeout_full_a: assert property (@(posedge clk) disable iff (rst)
    last_count_s |=> ctl.force_full)
    else $error("fail-safe expiry did not force full speed");
  late_access_a: assert property (@(posedge clk) disable iff (rst)
    (ctl.force_full && ctl.access) |=> release_s)
    else $error("access after expiry did not load defaults");
  early_access_a: assert property (@(posedge clk) disable iff (rst)
    ((st_q == FS_COUNT) && ctl.access) |=> !ctl.force_full [*4])
    else $error("early access still led to forced full speed");
endmodule

// ---- src/fpwm_top.sv ----
module fpwm_top import fpwm_pkg::*; #(
  parameter int FS_CYCLES  = FAILSAFE_CYCLES,
  parameter int DET_CYCLES = DETECT_CYCLES,
  parameter int PWM_DIV    = PWM_DIV_DEFAULT,
  parameter bit POLL_RAIL  = 1'b1
) (
  // Clock and reset
  input  wire logic                   CLK_SYS,
  input  wire logic                   RST,
  // Register access, one byte per register
  input  wire logic                   REG_WR_EN,
  input  wire logic                   REG_RD_EN,
  input  wire logic [7:0]             REG_ADDR,
  input  wire logic [7:0]             REG_WDATA,
  output logic [7:0]                  REG_RDATA,
  input  wire logic                   SMB_VALID_ACCESS,
  // Automatic loop and behaviour selection
  input  wire logic [3*FAN_OUTS-1:0]  DRIVE_BEHAVIOUR_SELECT,
  input  wire logic [8*FAN_OUTS-1:0]  AUTO_DUTY,
  // Core rail supervision
  input  wire logic                   CORE_RAIL_POWERED,
  input  wire logic                   CORE_RAIL_BELOW_LIMIT,
  input  wire logic                   CORE_RAIL_ALERT_EN,
  input  wire logic                   CORE_RAIL_FLAG_CLR,
  output logic                        CORE_RAIL_FLAG,
  output logic                        SMBALERT_O,
  output logic                        SMBALERT_OE_N,
  // Thermal limit pin and timer
  input  wire logic                   THERMAL_LIMIT_PIN_N,
  output logic [THERMAL_LIMIT_PIN_TIMER_W-1:0]    THERMAL_TIMER,
  // Start temperature tuning
  input  wire logic                   START_TEMP_ADJ_STB,
  input  wire logic [7:0]             START_TEMP_ADJ_VAL,
  output logic [7:0]                  FAN_START_TEMPERATURE,
  // Shutdown
  input  wire logic                   SHUTDOWN_REQ,
  output logic                        SHUTDOWN,
  // Fan drive pins
  input  wire logic [FAN_OUTS-1:0]    FAN_DRIVE_I,
  output logic [FAN_OUTS-1:0]         FAN_DRIVE_O,
  output logic [FAN_OUTS-1:0]         FAN_DRIVE_OE_N,
  output logic [FAN_OUTS-1:0]         FAN_SINK_EN,
  // Board test
  output logic                        XNOR_TEST_OUT
);
  localparam int DW = $clog2(DET_CYCLES + 1);
  localparam int VW = $clog2(PWM_DIV + 1);

  fpwm_ctl_if #(.N(FAN_OUTS)) ctl ();

  logic [FAN_OUTS-1:0][7:0]  duty_set_q;
  logic [FAN_OUTS-1:0][7:0]  applied_q;
  logic [FAN_OUTS-1:0]       manual;
  logic [7:0]                tune_q;
  logic [7:0]                board_test_q;
  logic [7:0]                detect_cfg_q;
  logic [FAN_OUTS-1:0]       presence_q;
  logic                      det_active_q;
  logic [DW-1:0]             det_cnt_q;
  logic [VW-1:0]             div_q;
  logic                      tick;
  logic                      freeze;
  logic                      flag_q;
  logic                      alert_q;
  logic [THERMAL_LIMIT_PIN_TIMER_W-1:0]  thermal_limit_pin_q;
  logic [7:0]                start_temp_q;
  logic                      shutdown_q;
  logic                      xnor_q;
  logic [7:0]                rdata_q;
  logic                      det_done;

  function automatic logic wr_hit(input logic [7:0] ofs);
    return REG_WR_EN && (REG_ADDR == ofs);
  endfunction

  function automatic logic [7:0] duty_ofs(input int i);
    return OFS_DUTY_1 + i[7:0];
  endfunction

  // Slow-rate enable for the drive counters and the thermal timer.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      div_q <= '0;
    end else if (div_q == VW'(PWM_DIV - 1)) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  assign tick = (div_q == VW'(PWM_DIV - 1));

  always_comb begin
    for (int i = 0; i < FAN_OUTS; i++) begin
      manual[i] = (DRIVE_BEHAVIOUR_SELECT[3*i +: 3] == DRIVE_BEHAVIOUR_SELECT_MANUAL);
    end
  end

  // Host duty codes only land while an output is manual.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      duty_set_q <= {FAN_OUTS{DUTY_RST}};
    end else begin
      for (int i = 0; i < FAN_OUTS; i++) begin
        if (ctl.load_defaults) begin
          duty_set_q[i] <= DUTY_RST;
        end else if (wr_hit(duty_ofs(i)) && manual[i]) begin
          duty_set_q[i] <= REG_WDATA;
        end
      end
    end
  end

  // The applied duty is what the pins run at and what reads return.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      applied_q <= {FAN_OUTS{DUTY_RST}};
    end else begin
      for (int i = 0; i < FAN_OUTS; i++) begin
        if (ctl.force_full) begin
          applied_q[i] <= DUTY_FULL;
        end else if (manual[i]) begin
          applied_q[i] <= duty_set_q[i];
        end else begin
          applied_q[i] <= AUTO_DUTY[8*i +: 8];
        end
      end
    end
  end

  assign ctl.tick    = tick;
  assign ctl.duty    = applied_q;
  assign ctl.rail_up = CORE_RAIL_POWERED;
  assign ctl.access  = SMB_VALID_ACCESS;

  fpwm_gen #(.N(FAN_OUTS)) u_gen (
    .clk (CLK_SYS),
    .rst (RST),
    .ctl (ctl.pwm)
  );

  fpwm_failsafe #(.FS_CYCLES(FS_CYCLES), .POLL_RAIL(POLL_RAIL)) u_fs (
    .clk (CLK_SYS),
    .rst (RST),
    .ctl (ctl.fs)
  );

  always_ff @(posedge CLK_SYS) begin
    if (RST || ctl.load_defaults) begin
      tune_q       <= TUNE_RST;
      board_test_q <= BOARD_TEST_RST;
    end else begin
      if (wr_hit(OFS_TUNE_CTRL)) begin
        tune_q <= REG_WDATA;
      end
      if (wr_hit(OFS_BOARD_TEST)) begin
        board_test_q <= REG_WDATA;
      end
    end
  end

  // Presence detection: the pins are released and sunk for the whole window,
  // then the sensed level is latched. A three-wire fan has no pullup on the
  // drive line, so it always reads absent.
  assign det_done = det_active_q && (det_cnt_q == DW'(DET_CYCLES - 1));

  always_ff @(posedge CLK_SYS) begin
    if (RST || ctl.load_defaults) begin
      detect_cfg_q <= DETECT_CFG_RST;
      det_active_q <= 1'b0;
      det_cnt_q    <= '0;
    end else begin
      if (wr_hit(OFS_DETECT_CFG)) begin
        detect_cfg_q[7:4] <= REG_WDATA[7:4];
      end
      if (det_active_q) begin
        if (det_done) begin
          det_active_q <= 1'b0;
        end else begin
          det_cnt_q <= det_cnt_q + 1'b1;
        end
      end else if (wr_hit(OFS_DETECT_CFG) && REG_WDATA[DET_START_BIT]) begin
        det_active_q <= 1'b1;
        det_cnt_q    <= '0;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST || ctl.load_defaults) begin
      presence_q <= '0;
    end else if (det_done) begin
      presence_q <= FAN_DRIVE_I;
    end
  end

  assign FAN_DRIVE_O    = ctl.drv;
  assign FAN_DRIVE_OE_N = {FAN_OUTS{det_active_q}};
  assign FAN_SINK_EN    = {FAN_OUTS{det_active_q}};

  // Core rail low hold.
  assign freeze = tune_q[HOLD_EN_BIT] && CORE_RAIL_BELOW_LIMIT;

  // Setting wins over a clear in the same cycle so no low event is lost.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      flag_q <= 1'b0;
    end else if (freeze) begin
      flag_q <= 1'b1;
    end else if (CORE_RAIL_FLAG_CLR) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= flag_q && CORE_RAIL_ALERT_EN;
    end
  end

  assign CORE_RAIL_FLAG = flag_q;
  assign SMBALERT_O     = 1'b0;
  assign SMBALERT_OE_N  = !alert_q;

  // The timer keeps its count across a low rail instead of restarting.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      thermal_limit_pin_q <= '0;
    end else if (!freeze && tick && !THERMAL_LIMIT_PIN_N && !(&thermal_limit_pin_q)) begin
      thermal_limit_pin_q <= thermal_limit_pin_q + 1'b1;
    end
  end
  assign THERMAL_TIMER = thermal_limit_pin_q;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      start_temp_q <= START_TEMP_RST;
    end else if (START_TEMP_ADJ_STB && !freeze) begin
      start_temp_q <= START_TEMP_ADJ_VAL;
    end
  end
  assign FAN_START_TEMPERATURE = start_temp_q;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      shutdown_q <= 1'b0;
    end else begin
      shutdown_q <= SHUTDOWN_REQ && !freeze;
    end
  end
  assign SHUTDOWN = shutdown_q;

  // Board continuity chain over the sensed inputs.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      xnor_q <= 1'b0;
    end else if (board_test_q[XEN_BIT]) begin
      xnor_q <= ~^{FAN_DRIVE_I, THERMAL_LIMIT_PIN_N, CORE_RAIL_BELOW_LIMIT};
    end else begin
      xnor_q <= 1'b0;
    end
  end
  assign XNOR_TEST_OUT = xnor_q;

  // Read data follows one cycle after the read strobe; unmapped reads give zero.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rdata_q <= 8'h00;
    end else if (REG_RD_EN) begin
      case (REG_ADDR)
        OFS_DUTY_1:     rdata_q <= applied_q[0];
        OFS_DUTY_2:     rdata_q <= applied_q[1];
        OFS_DUTY_3:     rdata_q <= applied_q[2];
        OFS_TUNE_CTRL:  rdata_q <= tune_q;
        OFS_BOARD_TEST: rdata_q <= board_test_q;
        OFS_DETECT_CFG: rdata_q <= {detect_cfg_q[7:4], presence_q, det_active_q};
        default:        rdata_q <= 8'h00;
      endcase
    end
  end
  assign REG_RDATA = rdata_q;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // The write decode is spelled out so that the properties see sampled strobes.
  sequence manual_write_s;
    REG_WR_EN && (REG_ADDR == OFS_DUTY_1) && manual[0] && !ctl.force_full
      && !ctl.load_defaults;
  endsequence

  manual_duty_a: assert property (manual_write_s ##1 manual[0] && !ctl.force_full
    |=> applied_q[0] == $past(REG_WDATA, 2))
    else $error("manual duty write did not reach the output");
  auto_duty_a: assert property (REG_WR_EN && (REG_ADDR == OFS_DUTY_1) && !manual[0]
    && !ctl.load_defaults |=> duty_set_q[0] == $past(duty_set_q[0]))
    else $error("duty write landed while not manual");
  detect_len_a: assert property ($rose(det_active_q)
    |-> det_active_q [*8] ##0 FAN_SINK_EN[0])
    else $error("detection window ended early or sink off");
  // The alert register follows the enable of the cycle before.
  rail_flag_a: assert property (freeze
    |=> flag_q ##1 (alert_q == $past(CORE_RAIL_ALERT_EN)))
    else $error("low core rail did not set flag and alert");
  thermal_limit_pin_hold_a: assert property (freeze |=> thermal_limit_pin_q == $past(thermal_limit_pin_q))
    else $error("thermal timer moved while rail low");
  temp_hold_a: assert property (freeze |=> start_temp_q == $past(start_temp_q))
    else $error("start temperature changed while rail low");
  no_shutdown_a: assert property (freeze |=> !shutdown_q)
    else $error("shutdown entered while rail low");
  resume_a: assert property (!freeze && SHUTDOWN_REQ |=> shutdown_q)
    else $error("shutdown not re-enabled after rail recovery");
  read_back_a: assert property (REG_RD_EN && REG_ADDR == OFS_DUTY_2
    |=> REG_RDATA == $past(applied_q[1]))
    else $error("duty read did not return applied duty");
  board_test_a: assert property (!board_test_q[XEN_BIT] |=> !XNOR_TEST_OUT)
    else $error("chain output active with test mode off");
endmodule

// ---- bench/fpwm_fan_model.sv ----
module fpwm_fan_model (
  // Clock for the floating-pin pattern
  input  wire logic        clk,
  // Drive pins as the device presents them
  input  wire logic [2:0]  drive_o,
  input  wire logic [2:0]  drive_oe_n,
  input  wire logic [2:0]  sink_en,
  // Which outputs carry a four-wire fan
  input  wire logic [2:0]  four_wire,
  output logic [2:0]       pin
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0] wander_q;

  // An undriven, unsunk pin without a four-wire fan toggles so that a stale level is never mistaken for a fan.
  initial wander_q = 3'h0;
  always @(posedge clk) begin
    wander_q <= ~wander_q;
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (!drive_oe_n[i]) begin
        pin[i] = drive_o[i];
      end else if (four_wire[i]) begin
        pin[i] = 1'b1;
      end else if (sink_en[i]) begin
        pin[i] = 1'b0;
      end else begin
        pin[i] = wander_q[i];
      end
    end
  end
endmodule

// ---- bench/fpwm_top_tb.sv ----
module fpwm_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FS = 50;
  localparam int DET = 16;
  localparam int LIMIT = 4000;

  logic        clk_sys, rst, wr_en, rd_en, smb_acc, rail_pwr, below, alert_en;
  logic        flag_clr, thermal_limit_pin_n, tadj_stb, shut_req, flag, alert_o, alert_oe_n;
  logic        shutdown, xnor_out;
  logic [7:0]  addr, wdata, rdata, tadj_val, start_temp, alt_rdata;
  logic [8:0]  drive_behaviour_select;
  logic [23:0] auto_duty;
  logic [15:0] ttimer, hold;
  logic [2:0]  pin_i, drv_o, drv_oe_n, sink_en, four_wire, alt_drv;
  int          num_errors, checks, cycles;

  fpwm_top #(.FS_CYCLES(FS), .DET_CYCLES(DET), .PWM_DIV(4), .POLL_RAIL(1'b1)) dut (
    .CLK_SYS(clk_sys), .RST(rst), .REG_WR_EN(wr_en), .REG_RD_EN(rd_en),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .SMB_VALID_ACCESS(smb_acc),
    .DRIVE_BEHAVIOUR_SELECT(drive_behaviour_select), .AUTO_DUTY(auto_duty), .CORE_RAIL_POWERED(rail_pwr),
    .CORE_RAIL_BELOW_LIMIT(below), .CORE_RAIL_ALERT_EN(alert_en),
    .CORE_RAIL_FLAG_CLR(flag_clr), .CORE_RAIL_FLAG(flag), .SMBALERT_O(alert_o),
    .SMBALERT_OE_N(alert_oe_n), .THERMAL_LIMIT_PIN_N(thermal_limit_pin_n), .THERMAL_TIMER(ttimer),
    .START_TEMP_ADJ_STB(tadj_stb), .START_TEMP_ADJ_VAL(tadj_val),
    .FAN_START_TEMPERATURE(start_temp), .SHUTDOWN_REQ(shut_req), .SHUTDOWN(shutdown),
    .FAN_DRIVE_I(pin_i), .FAN_DRIVE_O(drv_o), .FAN_DRIVE_OE_N(drv_oe_n),
    .FAN_SINK_EN(sink_en), .XNOR_TEST_OUT(xnor_out));

  // The fans-on variant shares every input and is judged on its duty and drive.
  fpwm_top #(.FS_CYCLES(FS), .DET_CYCLES(DET), .PWM_DIV(4), .POLL_RAIL(1'b0)) dut_fans_on (
    .CLK_SYS(clk_sys), .RST(rst), .REG_WR_EN(wr_en), .REG_RD_EN(rd_en),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(alt_rdata), .SMB_VALID_ACCESS(smb_acc),
    .DRIVE_BEHAVIOUR_SELECT(drive_behaviour_select), .AUTO_DUTY(auto_duty), .CORE_RAIL_POWERED(rail_pwr),
    .CORE_RAIL_BELOW_LIMIT(below), .CORE_RAIL_ALERT_EN(alert_en),
    .CORE_RAIL_FLAG_CLR(flag_clr), .CORE_RAIL_FLAG(), .SMBALERT_O(),
    .SMBALERT_OE_N(), .THERMAL_LIMIT_PIN_N(thermal_limit_pin_n), .THERMAL_TIMER(),
    .START_TEMP_ADJ_STB(tadj_stb), .START_TEMP_ADJ_VAL(tadj_val),
    .FAN_START_TEMPERATURE(), .SHUTDOWN_REQ(shut_req), .SHUTDOWN(),
    .FAN_DRIVE_I(pin_i), .FAN_DRIVE_O(alt_drv), .FAN_DRIVE_OE_N(),
    .FAN_SINK_EN(), .XNOR_TEST_OUT());

  fpwm_fan_model fans (.clk(clk_sys), .drive_o(drv_o), .drive_oe_n(drv_oe_n),
    .sink_en(sink_en), .four_wire(four_wire), .pin(pin_i));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      $display("[ERR] run length expected below %0d cycles seen %0d", LIMIT, cycles);
      num_errors++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask

  // Read data lands one edge after the strobe is taken and is looked at mid-cycle.
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk(what, {8'h00, exp}, {8'h00, rdata});
  endtask

  task automatic pulse_access;
    @(posedge clk_sys);
    smb_acc <= 1'b1;
    @(posedge clk_sys);
    smb_acc <= 1'b0;
  endtask

  task automatic adjust_start(input logic [7:0] v);
    @(posedge clk_sys);
    tadj_val <= v;
    tadj_stb <= 1'b1;
    @(posedge clk_sys);
    tadj_stb <= 1'b0;
  endtask

  task automatic do_reset;
    @(posedge clk_sys);
    rst <= 1'b1;
    tick(20);
    rst <= 1'b0;
  endtask

  task automatic test_reset;
    rd_chk("duty1", 8'h30, 8'hff);
    rd_chk("duty2", 8'h31, 8'hff);
    rd_chk("duty3", 8'h32, 8'hff);
    rd_chk("tuning", 8'h36, 8'h00);
    rd_chk("boardtest", 8'h6f, 8'h00);
    rd_chk("detectcfg", 8'h73, 8'h00);
    rd_chk("unmapped", 8'h10, 8'h00);
    chk("drive full", 16'h0007, {13'h0, drv_o});
    chk("start temp", 16'h009a, {8'h00, start_temp});
    chk("shutdown", 16'h0000, {15'h0, shutdown});
    $display("test reset done");
  endtask

  task automatic test_manual;
    tick(1);
    drive_behaviour_select      <= 9'h1c7;
    auto_duty <= 24'h005400;
    wr(8'h30, 8'h80);
    wr(8'h31, 8'h11);
    wr(8'h32, 8'h00);
    tick(2);
    rd_chk("manual duty1", 8'h30, 8'h80);
    chk("fans on duty1", 16'h00ff, {8'h00, alt_rdata});
    chk("fans on drive", 16'h0007, {13'h0, alt_drv});
    rd_chk("auto duty2", 8'h31, 8'h54);
    rd_chk("manual duty3", 8'h32, 8'h00);
    tick(1);
    auto_duty <= 24'h002a00;
    tick(3);
    rd_chk("auto duty2 moved", 8'h31, 8'h2a);
    $display("test manual done");
  endtask

  task automatic test_detect;
    tick(1);
    four_wire <= 3'b101;
    wr(8'h73, 8'h01);
    @(negedge clk_sys);
    chk("sink on", 16'h0007, {13'h0, sink_en});
    chk("released", 16'h0007, {13'h0, drv_oe_n});
    rd_chk("detect busy", 8'h73, 8'h01);
    tick(DET + 2);
    rd_chk("presence", 8'h73, 8'h0a);
    chk("sink off", 16'h0000, {13'h0, sink_en});
    chk("driven again", 16'h0000, {13'h0, drv_oe_n});
    $display("test detect done");
  endtask

  task automatic test_freeze;
    tick(1);
    thermal_limit_pin_n  <= 1'b0;
    shut_req <= 1'b1;
    tick(20);
    @(negedge clk_sys);
    chk("timer runs", 16'h0001, {15'h0, ttimer != 16'h0000});
    chk("shutdown free", 16'h0001, {15'h0, shutdown});
    wr(8'h36, 8'h02);
    below <= 1'b1;
    tick(4);
    @(negedge clk_sys);
    chk("rail flag", 16'h0001, {15'h0, flag});
    chk("alert masked", 16'h0001, {15'h0, alert_oe_n});
    hold = ttimer;
    tick(1);
    alert_en <= 1'b1;
    adjust_start(8'h40);
    tick(12);
    @(negedge clk_sys);
    chk("alert on", 16'h0000, {15'h0, alert_oe_n});
    chk("alert data", 16'h0000, {15'h0, alert_o});
    chk("timer held", hold, ttimer);
    chk("start frozen", 16'h009a, {8'h00, start_temp});
    chk("shutdown blocked", 16'h0000, {15'h0, shutdown});
    tick(1);
    below <= 1'b0;
    tick(2);
    @(negedge clk_sys);
    chk("shutdown back", 16'h0001, {15'h0, shutdown});
    adjust_start(8'h40);
    tick(12);
    @(negedge clk_sys);
    chk("start tuned", 16'h0040, {8'h00, start_temp});
    chk("timer resumes", 16'h0001, {15'h0, ttimer != hold});
    tick(1);
    flag_clr <= 1'b1;
    thermal_limit_pin_n  <= 1'b1;
    shut_req <= 1'b0;
    alert_en <= 1'b0;
    tick(1);
    flag_clr <= 1'b0;
    tick(2);
    @(negedge clk_sys);
    chk("flag cleared", 16'h0000, {15'h0, flag});
    $display("test freeze done");
  endtask

  task automatic test_xnor;
    tick(1);
    drive_behaviour_select <= 9'h1ff;
    wr(8'h30, 8'h00);
    wr(8'h31, 8'h00);
    wr(8'h32, 8'h00);
    wr(8'h6f, 8'h01);
    for (int k = 0; k < 2; k++) begin
      tick(1);
      thermal_limit_pin_n <= k[0];
      tick(6);
      @(negedge clk_sys);
      chk("drive zero", 16'h0000, {13'h0, drv_o});
      chk("xnor chain", {15'h0, ~^{pin_i, thermal_limit_pin_n, below}}, {15'h0, xnor_out});
    end
    wr(8'h6f, 8'h00);
    tick(3);
    @(negedge clk_sys);
    chk("xnor off", 16'h0000, {15'h0, xnor_out});
    $display("test xnor done");
  endtask

  // An early access keeps the fans under host control.
  task automatic test_failsafe_early;
    do_reset();
    tick(FS + 10);
    wr(8'h30, 8'h33);
    tick(2);
    rd_chk("rail low no force", 8'h30, 8'h33);
    tick(1);
    rail_pwr <= 1'b1;
    tick(5);
    pulse_access();
    wr(8'h30, 8'h33);
    tick(FS + 10);
    rd_chk("early access", 8'h30, 8'h33);
    $display("test failsafe early done");
  endtask

  task automatic test_failsafe_late;
    do_reset();
    rail_pwr <= 1'b0;
    wr(8'h30, 8'h10);
    wr(8'h36, 8'h02);
    rail_pwr <= 1'b1;
    tick(FS - 10);
    rd_chk("before expiry", 8'h30, 8'h10);
    tick(15);
    rd_chk("forced full", 8'h30, 8'hff);
    pulse_access();
    tick(3);
    rd_chk("defaults", 8'h36, 8'h00);
    wr(8'h30, 8'h20);
    tick(2);
    rd_chk("normal again", 8'h30, 8'h20);
    $display("test failsafe late done");
  endtask

  initial begin
    num_errors = 0;
    checks     = 0;
    cycles     = 0;
    rst = 1'b1; wr_en = 1'b0; rd_en = 1'b0; smb_acc = 1'b0; rail_pwr = 1'b0;
    below = 1'b0; alert_en = 1'b0; flag_clr = 1'b0; thermal_limit_pin_n = 1'b1;
    tadj_stb = 1'b0; shut_req = 1'b0; addr = 8'h00; wdata = 8'h00;
    tadj_val = 8'h00; drive_behaviour_select = 9'h1ff; auto_duty = 24'h000000; four_wire = 3'b000;
    tick(20);
    rst <= 1'b0;
    test_reset();
    test_manual();
    test_detect();
    test_freeze();
    test_xnor();
    test_failsafe_early();
    test_failsafe_late();
    give_verdict();
  end
endmodule
